/* File: core/acts_regs.svh */
// constants for the conversion timing and sync block
// assumes one master clock domain, pins sampled on sys_clk_i
`ifndef ACTS_REGS_SVH
`define ACTS_REGS_SVH

// ----------------------------------------------------------------
// clock division per output word
// ----------------------------------------------------------------
`define ACTS_DIV_HS_DIV1   12'd512
`define ACTS_DIV_HS_DIV0   12'd256
`define ACTS_DIV_LP_DIV1   12'd2560
`define ACTS_DIV_LP_DIV0   12'd512

// ----------------------------------------------------------------
// filter and settling
// ----------------------------------------------------------------
`define ACTS_OSR           12'd64
`define ACTS_OSR_SHIFT     6
`define ACTS_SETTLE_SPI    8'd129
`define ACTS_SETTLE_FS     8'd127
`define ACTS_WORD_W        16
`define ACTS_MAX_CH        8
`define ACTS_MIN_CLK_HZ    100000

`endif

/* File: core/acts_pkg.sv */
// types for the conversion timing and sync block
// assumes acts_regs.svh is available on the include path
package acts_pkg;
    `include "acts_regs.svh"

    // ------------------------------------------------------------
    // run state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ACTS_HALT   = 3'b001,
        ACTS_SETTLE = 3'b010,
        ACTS_VALID  = 3'b100
    } acts_state_e;

    // ------------------------------------------------------------
    // one result word set, all channels side by side
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`ACTS_MAX_CH-1:0][`ACTS_WORD_W-1:0] sample;
    } acts_word_s;
endpackage

/* File: core/acts_core.sv */
// conversion timing, mode tracking, sync restart and data-valid gating
// assumes control pins synchronous to sys_clk_i; modulator bits arrive per channel
`include "acts_regs.svh"
module acts_core
    import acts_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input  wire logic                sys_clk_i,
    input  wire logic                srst_i,
    input  wire logic                mode_i,
    input  wire logic                clock_divider_select_i,
    input  wire logic                sync_n_i,
    input  wire logic                protocol_frame_i,
    input  wire logic [CHANNELS-1:0] mod_bit_i,
    input  wire logic                out_ready_i,
    output logic                     out_valid_o,
    output acts_word_s               out_data_o,
    output logic                     ready_strobe_n_o,
    output logic                     settling_o,
    output logic                     low_power_o
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (CHANNELS < 1 || CHANNELS > `ACTS_MAX_CH) begin : g_bad_ch
        $error("CHANNELS out of range");
    end
    if ((1 << `ACTS_OSR_SHIFT) != `ACTS_OSR) begin : g_bad_osr
        $error("oversampling shift does not match ratio");
    end
    // tick counter is 6 bits wide; the slowest setting needs 40 clocks per tick
    if ((`ACTS_DIV_LP_DIV1 >> `ACTS_OSR_SHIFT) > 12'd64) begin : g_bad_tick
        $error("tick length exceeds counter");
    end
    if (`ACTS_SETTLE_SPI == 8'd0 || `ACTS_SETTLE_FS == 8'd0) begin : g_bad_settle
        $error("settling limit must be nonzero");
    end
    if (`ACTS_WORD_W != 16) begin : g_bad_word
        $error("result packing assumes 16-bit words");
    end

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [11:0] word_div(input logic lp, input logic dsel);
        logic [11:0] d;
        d = lp ? (dsel ? `ACTS_DIV_LP_DIV1 : `ACTS_DIV_LP_DIV0)
               : (dsel ? `ACTS_DIV_HS_DIV1 : `ACTS_DIV_HS_DIV0);
        return d;
    endfunction

    // acc spans -64..+64; +64 would overflow, so it clips to 7fff
    function automatic logic [15:0] sat_word(input logic signed [7:0] acc);
        logic [15:0] w;
        if (acc >= 8'sd64) begin
            w = 16'h7fff;
        end else if (acc <= -8'sd64) begin
            w = 16'h8000;
        end else begin
            w = {acc, 8'h00} << 1;
        end
        return w;
    endfunction

    // buffer fill after one edge; push and pop may fall in the same cycle
    function automatic logic [1:0] fill_next(input logic [1:0] fill, input logic wr, input logic rd);
        logic [1:0] f;
        case ({wr, rd})
            2'b10: begin
                f = fill + 2'd1;
            end
            2'b01: begin
                f = fill - 2'd1;
            end
            default: begin
                f = fill;
            end
        endcase
        return f;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    acts_state_e             state;
    acts_state_e             next_state;
    logic                    mode_last;
    logic [5:0]              tick_cnt;
    logic [5:0]              next_tick_cnt;
    logic [5:0]              samp_cnt;
    logic [5:0]              next_samp_cnt;
    logic [7:0]              settle_cnt;
    logic [7:0]              next_settle_cnt;
    logic signed [7:0]       lane_step [CHANNELS];
    logic signed [7:0]       acc [CHANNELS];
    acts_word_s              res;
    logic                    res_valid;
    acts_word_s              mem [2];
    logic                    wr_ptr;
    logic                    rd_ptr;
    logic [1:0]              count;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic        mode_change = mode_i != mode_last;
    wire logic        restart     = !sync_n_i || mode_change;
    wire logic [11:0] div_now     = word_div(mode_i, clock_divider_select_i);
    wire logic [11:0] tick_len    = div_now >> `ACTS_OSR_SHIFT;
    wire logic [7:0]  settle_lim  = protocol_frame_i ? `ACTS_SETTLE_FS : `ACTS_SETTLE_SPI;
    wire logic        fifo_full   = count == 2'd2;
    wire logic        fifo_empty  = count == 2'd0;
    wire logic        fifo_in_rdy = !fifo_full;
    // a full buffer stalls the modulator clock rather than drop a word
    wire logic        stall       = res_valid && !fifo_in_rdy;
    wire logic        running     = state != ACTS_HALT;
    // >= so a divider pin change in mid-word cannot run the counter through a wrap
    wire logic        tick        = running && !stall && (tick_cnt >= tick_len[5:0] - 6'd1);
    wire logic        conv_done   = tick && (samp_cnt == 6'(`ACTS_OSR - 12'd1));
    wire logic        last_settle = settle_cnt == settle_lim - 8'd1;
    wire logic        deliver     = conv_done && (state == ACTS_VALID || last_settle);
    wire logic        push        = res_valid && fifo_in_rdy;
    wire logic        pop         = out_valid_o && out_ready_i;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ACTS_HALT: begin
                if (sync_n_i) begin
                    next_state = ACTS_SETTLE;
                end
            end
            ACTS_SETTLE: begin
                if (conv_done && last_settle) begin
                    next_state = ACTS_VALID;
                end
            end
            ACTS_VALID: begin
                next_state = ACTS_VALID;
            end
            default: begin
                next_state = ACTS_HALT;
            end
        endcase
        if (!sync_n_i) begin
            next_state = ACTS_HALT;
        end else if (mode_change) begin
            next_state = ACTS_SETTLE;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state     <= ACTS_HALT;
            mode_last <= mode_i;
        end else begin
            state     <= next_state;
            mode_last <= mode_i;
        end
    end

    // ------------------------------------------------------------
    // modulator and word timing
    // ------------------------------------------------------------
    // every count derives from the master clock, so rate tracks its frequency
    always_comb begin
        next_tick_cnt = tick_cnt;
        next_samp_cnt = samp_cnt;
        if (restart || !running) begin
            next_tick_cnt = 6'd0;
            next_samp_cnt = 6'd0;
        end else if (tick) begin
            next_tick_cnt = 6'd0;
            next_samp_cnt = samp_cnt + 6'd1;
        end else if (!stall) begin
            next_tick_cnt = tick_cnt + 6'd1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tick_cnt <= 6'd0;
            samp_cnt <= 6'd0;
        end else begin
            tick_cnt <= next_tick_cnt;
            samp_cnt <= next_samp_cnt;
        end
    end

    always_comb begin
        next_settle_cnt = settle_cnt;
        if (restart) begin
            next_settle_cnt = 8'd0;
        end else if (conv_done && state == ACTS_SETTLE) begin
            next_settle_cnt = settle_cnt + 8'd1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            settle_cnt <= 8'd0;
        end else begin
            settle_cnt <= next_settle_cnt;
        end
    end

    // ------------------------------------------------------------
    // decimation, one accumulator per channel
    // ------------------------------------------------------------
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        assign lane_step[c] = mod_bit_i[c] ? 8'sd1 : -8'sd1;
        always_ff @(posedge sys_clk_i) begin
            if (srst_i || restart || !running) begin
                acc[c] <= 8'sd0;
            end else if (conv_done) begin
                acc[c] <= 8'sd0;
            end else if (tick) begin
                acc[c] <= acc[c] + lane_step[c];
            end
        end
    end

    // unused lanes keep their reset zero, so their data lines read low
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            res <= '0;
        end else if (conv_done) begin
            for (int k = 0; k < CHANNELS; k++) begin
                res.sample[k] <= sat_word(acc[k] + lane_step[k]);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || restart) begin
            res_valid <= 1'b0;
        end else if (deliver) begin
            res_valid <= 1'b1;
        end else if (push) begin
            res_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // two-entry buffer, flushed on restart
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || restart) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr <= !wr_ptr;
            end
            if (pop) begin
                rd_ptr <= !rd_ptr;
            end
            count <= fill_next(count, push, pop);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mem[0] <= '0;
            mem[1] <= '0;
        end else if (push) begin
            mem[wr_ptr] <= res;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // empty buffer shows all-zero data, so frame-sync lines read low
    assign out_valid_o      = !fifo_empty;
    assign out_data_o       = fifo_empty ? '0 : mem[rd_ptr];
    // in frame-sync the strobe pin is an input on the far side; idle high here
    assign ready_strobe_n_o = protocol_frame_i ? 1'b1 : fifo_empty;
    assign settling_o       = state != ACTS_VALID;
    assign low_power_o      = mode_last;

endmodule

/* File: dv/acts_core_props.sv */
// checker for acts_core port timing
// assumes it is bound onto every acts_core instance
module acts_core_props
    import acts_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input wire logic                sys_clk_i,
    input wire logic                srst_i,
    input wire logic                mode_i,
    input wire logic                clock_divider_select_i,
    input wire logic                sync_n_i,
    input wire logic                protocol_frame_i,
    input wire logic [CHANNELS-1:0] mod_bit_i,
    input wire logic                out_ready_i,
    input wire logic                out_valid_o,
    input wire acts_word_s          out_data_o,
    input wire logic                ready_strobe_n_o,
    input wire logic                settling_o,
    input wire logic                low_power_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // ----------------------------------------------------------------
    // settling length, restarted by sync and mode change
    // ----------------------------------------------------------------
    int cnt;
    int div;
    int lim;
    assign div = low_power_o ? (clock_divider_select_i ? 2560 : 512) : (clock_divider_select_i ? 512 : 256);
    assign lim = protocol_frame_i ? 127 : 129;
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !sync_n_i || mode_i != low_power_o || !settling_o) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    AST_SYNC_FLUSH: assert property (!sync_n_i |=> !out_valid_o && settling_o)
        else $error("sync low did not flush");
    AST_SYNC_STROBE: assert property (!sync_n_i && !protocol_frame_i |=> ready_strobe_n_o)
        else $error("strobe low during sync");
    AST_SPI_STROBE: assert property (!protocol_frame_i && !$past(protocol_frame_i) |-> ready_strobe_n_o == !out_valid_o)
        else $error("strobe disagrees with valid");
    AST_FRAME_STROBE: assert property (protocol_frame_i && $past(protocol_frame_i) |-> ready_strobe_n_o)
        else $error("strobe low in frame mode");
    AST_MODE_REG: assert property (1'b1 |=> low_power_o == $past(mode_i))
        else $error("mode not tracked");
    AST_MODE_RESTART: assert property (mode_i != low_power_o |-> ##2 (settling_o && !out_valid_o))
        else $error("mode change did not restart");
    AST_VALID_GATE: assert property (out_valid_o |-> !settling_o)
        else $error("data while settling");
    AST_SETTLE_TIME: assert property ($fell(settling_o) |-> cnt >= (lim - 1) * div && cnt <= (lim + 1) * div)
        else $error("settling length wrong");
    cover property ($fell(settling_o) && protocol_frame_i);
    cover property ($fell(settling_o) && !protocol_frame_i);
    cover property (out_valid_o && !out_ready_i ##1 out_valid_o);
endmodule

bind acts_core acts_core_props #(.CHANNELS(CHANNELS)) u_acts_core_props (.sys_clk_i, .srst_i, .mode_i,
    .clock_divider_select_i, .sync_n_i, .protocol_frame_i, .mod_bit_i, .out_ready_i, .out_valid_o,
    .out_data_o, .ready_strobe_n_o, .settling_o, .low_power_o);

/* File: dv/acts_host_model.sv */
// host side model: modulator bit source and word consumer
// assumes the core samples on the rising edge
module acts_host_model (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] mask_i,
    input  wire logic       hold_i,
    output logic      [7:0] mod_bit_o,
    output logic            out_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial mod_bit_o = 8'h00;
    initial out_ready_o = 1'b0;
    // random stalls, hold_i forces a long one to fill the buffer
    always @(negedge sys_clk_i) begin
        mod_bit_o <= mask_i;
        out_ready_o <= !hold_i && ($urandom() % 4 != 0);
    end
endmodule

/* File: dv/tb_acts_core.sv */
// top bench for acts_core: restart, settling timing, buffered stream
// assumes acts_core_props bound and acts_host_model as the consumer
module tb_acts_core
    import acts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic       mode = 1'b0;
    logic       sync_n = 1'b1;
    logic       frame = 1'b0;
    logic       cds = 1'b0;
    logic       hold = 1'b0;
    logic [7:0] mask = 8'h01;
    logic [7:0] mbit;
    logic       rdy;
    logic       vld;
    logic       strb;
    logic       settl;
    logic       lp;
    acts_word_s data;
    int         err_count = 0;
    int         check_count = 0;
    always #10 clk = ~clk;
    acts_core #(.CHANNELS(8)) u_acts_core (.sys_clk_i(clk), .srst_i(srst), .mode_i(mode),
        .clock_divider_select_i(cds), .sync_n_i(sync_n), .protocol_frame_i(frame), .mod_bit_i(mbit),
        .out_ready_i(rdy), .out_valid_o(vld), .out_data_o(data), .ready_strobe_n_o(strb),
        .settling_o(settl), .low_power_o(lp));
    acts_host_model u_acts_host_model (.sys_clk_i(clk), .mask_i(mask), .hold_i(hold), .mod_bit_o(mbit),
        .out_ready_o(rdy));
    // constant bits saturate every channel: ones high, zeros low
    function automatic acts_word_s exp_word(input logic [7:0] m);
        acts_word_s w;
        for (int c = 0; c < 8; c++) begin
            w.sample[c] = m[c] ? 16'h7fff : 16'h8000;
        end
        return w;
    endfunction
    always @(posedge clk) begin
        if (!srst && vld === 1'b1 && rdy) `CHK("word", exp_word(mask), data)
    end
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // frame-sync host watches the data lines for the first 1; spi host waits on valid
    function automatic logic arrived();
        return frame ? ((|data.sample) === 1'b1) : (vld === 1'b1);
    endfunction
    // n0 counts the negedges already spent since the restart edge
    task automatic wait_first(input int lo, input int hi, input int div, input int n0);
        int n;
        n = n0;
        while (!arrived() && n < 140 * div) begin
            @(negedge clk);
            n++;
        end
        `CHK("first", 1'b1, n >= lo * div && n <= hi * div + 8)
        if (!arrived()) finish_test();
    endtask
    initial begin
        void'($urandom(32'h81a0));
        mask = 8'($urandom()) | 8'h01;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        wait_first(128, 129, 256, 0);
        `CHK("strobe", 1'b0, strb)
        `CHK("settle", 1'b0, settl)
        hold = 1'b1;
        repeat (800) @(negedge clk);
        `CHK("held", 1'b1, vld)
        hold = 1'b0;
        repeat (40) @(negedge clk);
        sync_n = 1'b0;
        @(negedge clk);
        `CHK("flush", 1'b0, vld)
        `CHK("strobe_hi", 1'b1, strb)
        `CHK("halt", 1'b1, settl)
        frame = 1'b1;
        cds = 1'b1;
        mask = 8'($urandom()) | 8'h01;
        sync_n = 1'b1;
        @(negedge clk);
        `CHK("restart", 1'b1, settl)
        mode = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("lp", 1'b1, lp)
        mode = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("hs", 1'b0, lp)
        `CHK("fs_low", 128'h0, data)
        wait_first(127, 128, 512, 3);
        `CHK("fs_strobe", 1'b1, strb)
        repeat (600) @(negedge clk);
        finish_test();
    end
endmodule
